// file: src/sync_serial_tail_mark_port_params.svh
// register indices, field positions, reset values and timing counts of the serial port
// assumes a 32-bit apb bus where each register index maps to byte address index*4
`ifndef SYNC_SERIAL_TAIL_MARK_PORT_PARAMS_SVH
`define SYNC_SERIAL_TAIL_MARK_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SSP_IDX_MODE_CTRL 16'hffa0
`define SSP_IDX_CTRL_STAT 16'hffa1
`define SSP_IDX_DATA_UPPER 16'hffa2
`define SSP_IDX_DATA_LOWER 16'hffa3
`define SSP_IDX_PIN_CFG 16'hffa4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SSP_BIT_SO_LEVEL 6
`define SSP_BIT_OVERRUN 5
`define SSP_BIT_TAIL_SENDING 1
`define SSP_BIT_START 0
`define SSP_BIT_OPEN_DRAIN 0

// ----------------------------------------------------------------------
// reset values and fixed read patterns
// ----------------------------------------------------------------------
`define SSP_MODE_CTRL_RESET 8'h00
`define SSP_CTRL_STAT_RESET 8'h9c
`define SSP_CTRL_STAT_FIXED 8'h9c

// ----------------------------------------------------------------------
// operation mode codes
// ----------------------------------------------------------------------
`define SSP_OPM_8BIT 2'h0
`define SSP_OPM_16BIT 2'h1
`define SSP_OPM_CONT_CLK 2'h2

// ----------------------------------------------------------------------
// prescaler divide ratios per rate code, and tail length in serial clocks
// ----------------------------------------------------------------------
`define SSP_DIV_0 11'h0400
`define SSP_DIV_1 11'h0100
`define SSP_DIV_2 11'h0040
`define SSP_DIV_3 11'h0020
`define SSP_DIV_4 11'h0010
`define SSP_DIV_5 11'h0008
`define SSP_DIV_6 11'h0004
`define SSP_DIV_7 11'h0002
`define SSP_TAIL_CLKS 5'h01

`endif

// file: src/sync_serial_pkg.sv
// types shared by the serial port: mode register layout, phase enum and module state
// assumes the _params header supplies every numeric constant
package sync_serial_pkg;

	// ----------------------------------------------------------------------
	// mode control register layout
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] op_mode;            // op_mode_hi, op_mode_lo
		logic tail_marker_enable;       // tail marker after each word
		logic tail_type_select;         // 0 hold tail, 1 latch tail
		logic clock_source_select;      // 0 internal, 1 external
		logic [2:0] rate_sel;           // prescaler tap
	} mode_ctrl_t;

	// transfer phase
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_DATA,
		PH_TAIL
	} phase_t;

	// ----------------------------------------------------------------------
	// whole state of the port
	// ----------------------------------------------------------------------
	typedef struct packed {
		mode_ctrl_t mode;               // mode control register
		logic open_drain;               // transmit output open drain
		phase_t phase;                  // transfer phase
		logic start_flag;               // busy flag
		logic overrun_flag;             // sticky overrun
		logic overrun_seen;             // overrun read as one
		logic [15:0] sdr;               // upper and lower data bytes
		logic [4:0] bit_cnt;            // clocks done in this phase
		logic [9:0] div_cnt;            // prescaler half period count
		logic sck;                      // serial clock level driven
		logic sck_prev;                 // previous external clock sample
		logic so;                       // transmit level
		logic done_pulse;               // transfer complete request
		logic pready;                   // apb ready
		logic pslverr;                  // apb error
		logic [31:0] prdata;            // apb read data
	} port_state_t;

endpackage : sync_serial_pkg

// file: src/sync_serial_tail_mark_port.sv
// synchronous serial port, channel one: lsb-first 8/16-bit shifter with tail marker
// assumes an apb master on CLK_IN and pin inputs already synchronous to CLK_IN
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_tail_mark_port_params.svh"

// What this block does
// - words of 8 or 16 bits
// - mode field picks 8-bit, 16-bit, continuous clock
// - reset clears mode control register
// - mode register write aborts running transfer
// - marker enable adds tail after each word
// - tail type picks hold or latch tail
// - clock source picks internal output or external input
// - rate field divides system clock 1024 down to 2
// - interrupt request on every transfer completion
// - pins: two-way clock, data in, data out
// - transmit output may be open drain
// - lsb first, change on fall, sample on rise
// - start flag begins transfer, reads busy, self-clears
// - external clock after completion sets overrun flag
// - continuous mode drives internal clock at selected rate without pause
module sync_serial_tail_mark_port (
	input wire logic CLK_IN,              // system clock, 125 MHz
	input wire logic SYS_RST_IN,          // synchronous reset, active high
	input wire logic PSEL_IN,             // apb select
	input wire logic PENABLE_IN,          // apb access phase
	input wire logic PWRITE_IN,           // apb direction, 1 write
	input wire logic [31:0] PADDR_IN,     // apb byte address
	input wire logic [31:0] PWDATA_IN,    // apb write data
	output logic [31:0] PRDATA_OUT,       // apb read data
	output logic PREADY_OUT,              // apb ready
	output logic PSLVERR_OUT,             // apb error on unmapped address
	input wire logic SCK_PIN_IN,          // serial clock pin level
	output logic SCK_PIN_OUT,             // serial clock driven level
	output logic SCK_PIN_OE_OUT,          // serial clock drive enable
	input wire logic SI_PIN_IN,           // serial receive data
	output logic SO_PIN_OUT,              // serial transmit level
	output logic SO_PIN_OE_OUT,           // serial transmit drive enable
	output logic XFER_DONE_IRQ_OUT        // one-cycle transfer complete request
);

	// ----------------------------------------------------------------------
	// state and decode signals
	// ----------------------------------------------------------------------
	sync_serial_pkg::port_state_t st_r;   // registered state
	sync_serial_pkg::port_state_t st_nxt; // next state
	logic setup_phase;                    // apb setup cycle
	logic access_wr;                      // write takes effect this edge
	logic access_rd;                      // read completes this edge
	logic [31:0] addr_mode;               // byte address of mode control
	logic [31:0] addr_stat;               // byte address of control status
	logic [31:0] addr_upper;              // byte address of upper data
	logic [31:0] addr_lower;              // byte address of lower data
	logic [31:0] addr_pin;                // byte address of pin config
	logic [9:0] half_cnt;                 // half period minus one
	logic int_toggle;                     // internal clock toggles now
	logic fall_evt;                       // serial clock falling edge
	logic rise_evt;                       // serial clock rising edge
	logic cont_mode;                      // continuous clock mode
	logic [7:0] stat_rd;                  // control status read value
	logic [4:0] word_bits;                // bits in a word

	assign addr_mode = {14'h0000, `SSP_IDX_MODE_CTRL, 2'b00};
	assign addr_stat = {14'h0000, `SSP_IDX_CTRL_STAT, 2'b00};
	assign addr_upper = {14'h0000, `SSP_IDX_DATA_UPPER, 2'b00};
	assign addr_lower = {14'h0000, `SSP_IDX_DATA_LOWER, 2'b00};
	assign addr_pin = {14'h0000, `SSP_IDX_PIN_CFG, 2'b00};

	// ----------------------------------------------------------------------
	// prescaler half period for a rate code
	// ----------------------------------------------------------------------
	function automatic logic [9:0] half_of(input logic [2:0] sel);
		logic [10:0] d;
		case (sel)
			3'h0: d = `SSP_DIV_0;
			3'h1: d = `SSP_DIV_1;
			3'h2: d = `SSP_DIV_2;
			3'h3: d = `SSP_DIV_3;
			3'h4: d = `SSP_DIV_4;
			3'h5: d = `SSP_DIV_5;
			3'h6: d = `SSP_DIV_6;
			default: d = `SSP_DIV_7;
		endcase
		half_of = d[10:1] - 10'h001;
	endfunction : half_of

	// ----------------------------------------------------------------------
	// combinational helpers: apb phases, clock events, status image
	// ----------------------------------------------------------------------
	always_comb begin
		setup_phase = PSEL_IN & ~PENABLE_IN;
		// pready is raised for exactly the access cycle after setup
		access_wr = PSEL_IN & PENABLE_IN & st_r.pready & PWRITE_IN;
		access_rd = PSEL_IN & PENABLE_IN & st_r.pready & ~PWRITE_IN;
		cont_mode = (st_r.mode.op_mode == `SSP_OPM_CONT_CLK);
		word_bits = (st_r.mode.op_mode == `SSP_OPM_16BIT) ? 5'h10 : 5'h08;
		half_cnt = half_of(st_r.mode.rate_sel);
		// internal clock runs only while a transfer or continuous output needs it
		int_toggle = ~st_r.mode.clock_source_select &
			(cont_mode | (st_r.phase != sync_serial_pkg::PH_IDLE)) &
			(st_r.div_cnt == half_cnt);
		if (st_r.mode.clock_source_select) begin
			fall_evt = st_r.sck_prev & ~SCK_PIN_IN;
			rise_evt = ~st_r.sck_prev & SCK_PIN_IN;
		end else begin
			fall_evt = int_toggle & st_r.sck;
			rise_evt = int_toggle & ~st_r.sck;
		end
		stat_rd = `SSP_CTRL_STAT_FIXED;
		stat_rd[`SSP_BIT_SO_LEVEL] = st_r.so;
		stat_rd[`SSP_BIT_OVERRUN] = st_r.overrun_flag;
		stat_rd[`SSP_BIT_TAIL_SENDING] = (st_r.phase == sync_serial_pkg::PH_TAIL);
		stat_rd[`SSP_BIT_START] = st_r.start_flag;
	end

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.done_pulse = 1'b0;
		st_nxt.sck_prev = SCK_PIN_IN;

		// apb answer: ready and read data prepared during setup
		st_nxt.pready = setup_phase;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata = 32'h0000_0000;
		if (setup_phase) begin
			if (PADDR_IN == addr_mode) begin
				st_nxt.prdata = {24'h00_0000, st_r.mode};
			end else if (PADDR_IN == addr_stat) begin
				st_nxt.prdata = {24'h00_0000, stat_rd};
			end else if (PADDR_IN == addr_upper) begin
				st_nxt.prdata = {24'h00_0000, st_r.sdr[15:8]};
			end else if (PADDR_IN == addr_lower) begin
				st_nxt.prdata = {24'h00_0000, st_r.sdr[7:0]};
			end else if (PADDR_IN == addr_pin) begin
				st_nxt.prdata = {31'h0000_0000, st_r.open_drain};
			end else begin
				st_nxt.pslverr = 1'b1; // unmapped address
			end
		end

		// prescaler count, cleared on each toggle
		if (int_toggle) begin
			st_nxt.div_cnt = 10'h000;
			st_nxt.sck = ~st_r.sck;
		end else if (~st_r.mode.clock_source_select &
			(cont_mode | (st_r.phase != sync_serial_pkg::PH_IDLE))) begin
			st_nxt.div_cnt = st_r.div_cnt + 10'h001;
		end else begin
			st_nxt.div_cnt = 10'h000;
			st_nxt.sck = 1'b1; // clock rests high between transfers
		end

		// shift engine
		case (st_r.phase)
			sync_serial_pkg::PH_IDLE: begin
				// external clock after completion is an overrun
				if (st_r.mode.clock_source_select & rise_evt) begin
					st_nxt.overrun_flag = 1'b1;
				end
			end
			sync_serial_pkg::PH_DATA: begin
				if (fall_evt) begin
					st_nxt.so = st_r.sdr[0];
				end
				if (rise_evt) begin
					// received bit enters at the top of the active word
					if (word_bits == 5'h10) begin
						st_nxt.sdr = {SI_PIN_IN, st_r.sdr[15:1]};
					end else begin
						st_nxt.sdr[7:0] = {SI_PIN_IN, st_r.sdr[7:1]};
					end
					st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
					if (st_r.bit_cnt + 5'h01 == word_bits) begin
						st_nxt.bit_cnt = 5'h00;
						if (st_r.mode.tail_marker_enable) begin
							st_nxt.phase = sync_serial_pkg::PH_TAIL;
						end else begin
							st_nxt.phase = sync_serial_pkg::PH_IDLE;
							st_nxt.start_flag = 1'b0;
							st_nxt.done_pulse = 1'b1;
						end
					end
				end
			end
			sync_serial_pkg::PH_TAIL: begin
				// hold tail holds data low, latch tail drives it high
				if (fall_evt) begin
					st_nxt.so = st_r.mode.tail_type_select;
				end
				if (rise_evt) begin
					st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
					if (st_r.bit_cnt + 5'h01 == `SSP_TAIL_CLKS) begin
						st_nxt.bit_cnt = 5'h00;
						st_nxt.phase = sync_serial_pkg::PH_IDLE;
						st_nxt.start_flag = 1'b0;
						st_nxt.done_pulse = 1'b1;
					end
				end
			end
			default: begin
				st_nxt.phase = sync_serial_pkg::PH_IDLE;
			end
		endcase

		// register writes
		if (access_wr) begin
			if (PADDR_IN == addr_mode) begin
				st_nxt.mode = PWDATA_IN[7:0];
				// a mode write stops any transfer without a completion request
				st_nxt.phase = sync_serial_pkg::PH_IDLE;
				st_nxt.start_flag = 1'b0;
				st_nxt.bit_cnt = 5'h00;
				st_nxt.done_pulse = 1'b0;
			end else if (PADDR_IN == addr_stat) begin
				// start is ignored while busy or in continuous clock mode
				if (PWDATA_IN[`SSP_BIT_START] & ~st_r.start_flag & ~cont_mode) begin
					st_nxt.start_flag = 1'b1;
					st_nxt.phase = sync_serial_pkg::PH_DATA;
					st_nxt.bit_cnt = 5'h00;
					st_nxt.div_cnt = 10'h000;
				end
				// level override only outside a transfer
				if (st_r.phase == sync_serial_pkg::PH_IDLE) begin
					st_nxt.so = PWDATA_IN[`SSP_BIT_SO_LEVEL];
				end
				// clear needs a prior read of one; a new overrun wins
				if (~PWDATA_IN[`SSP_BIT_OVERRUN] & st_r.overrun_seen &
					~(st_r.mode.clock_source_select & rise_evt &
					(st_r.phase == sync_serial_pkg::PH_IDLE))) begin
					st_nxt.overrun_flag = 1'b0;
					st_nxt.overrun_seen = 1'b0;
				end
			end else if (PADDR_IN == addr_upper) begin
				st_nxt.sdr[15:8] = PWDATA_IN[7:0];
			end else if (PADDR_IN == addr_lower) begin
				st_nxt.sdr[7:0] = PWDATA_IN[7:0];
			end else if (PADDR_IN == addr_pin) begin
				st_nxt.open_drain = PWDATA_IN[`SSP_BIT_OPEN_DRAIN];
			end
		end
		// remember that software saw the overrun flag set
		if (access_rd & (PADDR_IN == addr_stat) & st_r.overrun_flag) begin
			st_nxt.overrun_seen = 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			st_r <= '0;
			st_r.mode <= `SSP_MODE_CTRL_RESET;
			st_r.phase <= sync_serial_pkg::PH_IDLE;
			st_r.sck <= 1'b1;
			st_r.sck_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------------
	// the clock pin drives only with the internal source selected
	assign SCK_PIN_OUT = st_r.sck;
	assign SCK_PIN_OE_OUT = ~st_r.mode.clock_source_select;
	// open drain drives only the low level; the pull-up gives the high
	assign SO_PIN_OUT = st_r.so & ~st_r.open_drain;
	assign SO_PIN_OE_OUT = ~st_r.open_drain | ~st_r.so;
	assign XFER_DONE_IRQ_OUT = st_r.done_pulse;
	assign PRDATA_OUT = st_r.prdata;
	assign PREADY_OUT = st_r.pready;
	assign PSLVERR_OUT = st_r.pslverr & st_r.pready;

endmodule : sync_serial_tail_mark_port
`default_nettype wire

// file: verif/sync_serial_tail_mark_port_assertions.sv
// pin-level checks on the serial port top
// assumes one clock and a synchronous active-high reset; bound at the foot
`timescale 1ns/1ns
`default_nettype none
module ssp_pin_checker (
	input wire logic CLK_IN, // system clock
	input wire logic SYS_RST_IN, // reset
	input wire logic PSEL_IN, // apb select
	input wire logic PENABLE_IN, // apb access
	input wire logic PWRITE_IN, // apb direction
	input wire logic PREADY_OUT, // apb ready
	input wire logic PSLVERR_OUT, // apb error
	input wire logic SCK_PIN_OUT, // clock level
	input wire logic SCK_PIN_OE_OUT, // clock enable
	input wire logic SO_PIN_OUT, // transmit level
	input wire logic XFER_DONE_IRQ_OUT // completion pulse
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	property p_ready_after_setup;
		PSEL_IN && !PENABLE_IN |=> PREADY_OUT;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready late");
	property p_ready_in_access;
		PREADY_OUT |-> PSEL_IN && PENABLE_IN && $past(PSEL_IN && !PENABLE_IN);
	endproperty
	a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
	property p_ready_once;
		PREADY_OUT |=> !PREADY_OUT;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready too long");
	property p_err_ready;
		PSLVERR_OUT |-> PREADY_OUT;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_irq_pulse;
		XFER_DONE_IRQ_OUT |=> !XFER_DONE_IRQ_OUT;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	// data may only move while the clock is low, apart from register writes
	property p_so_on_fall;
		$changed(SO_PIN_OUT) && SCK_PIN_OE_OUT && !$past(PSEL_IN && PENABLE_IN) |-> !SCK_PIN_OUT;
	endproperty
	a_so_on_fall: assert property (p_so_on_fall) else $error("data moved, clock high");
	property p_irq_sck_high;
		XFER_DONE_IRQ_OUT && SCK_PIN_OE_OUT |-> SCK_PIN_OUT;
	endproperty
	a_irq_sck_high: assert property (p_irq_sck_high) else $error("done, clock low");
	property p_oe_by_write;
		$changed(SCK_PIN_OE_OUT) |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN);
	endproperty
	a_oe_by_write: assert property (p_oe_by_write) else $error("clock dir moved");
	// cleared mode register means internal clock, pin driven and resting high
	property p_reset_state;
		$fell(SYS_RST_IN) |-> SCK_PIN_OE_OUT && SCK_PIN_OUT && !PREADY_OUT && !XFER_DONE_IRQ_OUT;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state after reset");
endmodule : ssp_pin_checker
bind sync_serial_tail_mark_port ssp_pin_checker i_pin_chk (
	.CLK_IN(CLK_IN),
	.SYS_RST_IN(SYS_RST_IN),
	.PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN),
	.PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT),
	.SCK_PIN_OUT(SCK_PIN_OUT),
	.SCK_PIN_OE_OUT(SCK_PIN_OE_OUT),
	.SO_PIN_OUT(SO_PIN_OUT),
	.XFER_DONE_IRQ_OUT(XFER_DONE_IRQ_OUT)
);
`default_nettype wire

// file: verif/serial_peer_model.sv
// far-side peripheral: sends a word lsb first on si, captures so
// assumes resolved pin levels, sampled on the system clock
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
	input wire logic clk_in, // system clock
	input wire logic sck_in, // resolved serial clock
	input wire logic so_in, // resolved transmit line
	input wire logic load_in, // load word, clear capture
	input wire logic [15:0] tx_word_in, // word to send
	output logic si_out, // line into the port
	output logic [15:0] rx_word_out // first bit ends lowest
);
	logic prev_r = 1'b1; // last clock sample, clock idles high
	logic si_r = 1'b0; // level held between falls
	logic [15:0] sh_r; // bits still to send
	// the new bit shows in the cycle the clock falls, so even the div-2 rate samples it in time
	assign si_out = (prev_r && !sck_in) ? sh_r[0] : si_r;
	always_ff @(posedge clk_in) begin
		prev_r <= sck_in;
		if (load_in) begin
			sh_r <= tx_word_in;
			rx_word_out <= 16'h0000;
			si_r <= ~si_r; // no stale level between frames
		end else if (prev_r && !sck_in) begin
			si_r <= sh_r[0];
			sh_r <= {~sh_r[0], sh_r[15:1]};
		end else if (!prev_r && sck_in) begin
			rx_word_out <= {so_in, rx_word_out[15:1]};
		end
	end
endmodule : serial_peer_model
`default_nettype wire

// file: verif/test_sync_serial_tail_mark_port.sv
// bench for the serial port: registers, transfers, tail, abort, overrun
// assumes the port, its header and the peer model are compiled with it
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_tail_mark_port_params.svh"
module test_sync_serial_tail_mark_port;
	localparam logic [15:0] i_mode = `SSP_IDX_MODE_CTRL;
	localparam logic [15:0] i_stat = `SSP_IDX_CTRL_STAT;
	localparam logic [15:0] i_hi = `SSP_IDX_DATA_UPPER;
	localparam logic [15:0] i_lo = `SSP_IDX_DATA_LOWER;
	localparam logic [15:0] i_pin = `SSP_IDX_PIN_CFG;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [31:0] paddr = 32'h0000_0000, pwd = 32'h0000_0000, rdata;
	logic ext_sck = 1'b1, pld = 1'b0; // external clock rests high
	logic [15:0] ptx = 16'h0000, prx; // peer word out and captured
	logic si, sck_lvl, so_lvl, rdy, serr, sck_o, sck_oe, so_o, so_oe, irq;
	logic [9:0] q[$]; // expected {read, error, data}
	logic [9:0] e;
	logic [10:0] dv[8] = '{`SSP_DIV_0, `SSP_DIV_1, `SSP_DIV_2, `SSP_DIV_3,
		`SSP_DIV_4, `SSP_DIV_5, `SSP_DIV_6, `SSP_DIV_7};
	int bad_count = 0, checks_done = 0, irq_cnt = 0, seed = 58572;
	assign sck_lvl = sck_oe ? sck_o : ext_sck;
	assign so_lvl = so_oe ? so_o : 1'b1; // pull-up on open drain
	initial forever #4 clk = ~clk;
	sync_serial_tail_mark_port i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
		.PRDATA_OUT(rdata), .PREADY_OUT(rdy), .PSLVERR_OUT(serr), .SCK_PIN_IN(sck_lvl),
		.SCK_PIN_OUT(sck_o), .SCK_PIN_OE_OUT(sck_oe), .SI_PIN_IN(si), .SO_PIN_OUT(so_o),
		.SO_PIN_OE_OUT(so_oe), .XFER_DONE_IRQ_OUT(irq));
	serial_peer_model i_peer (.clk_in(clk), .sck_in(sck_lvl), .so_in(so_lvl),
		.load_in(pld), .tx_word_in(ptx), .si_out(si), .rx_word_out(prx));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	// one apb transfer; read results are judged by the monitor
	task automatic bus(input logic wr, input logic [15:0] ix, input logic [7:0] wd,
		input logic [7:0] ex, input logic er);
		int n;
		q.push_back({~wr, er, ex});
		psel <= 1'b1;
		pwr <= wr;
		paddr <= {14'h0000, ix, 2'b00};
		pwd <= {24'h00_0000, wd};
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
		chk(n < 50, "no ready");
		if (n >= 50) give_verdict;
	endtask : bus
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		chk(n < 20000, "no completion");
		if (n >= 20000) give_verdict;
		@(posedge clk); // the peer takes the last bit one cycle after the final rise
	endtask : wait_irq
	task automatic xfer(input logic [7:0] md, input logic [15:0] dw, input logic [15:0] pw);
		bus(1'b1, i_mode, md, 8'h00, 1'b0);
		bus(1'b1, i_lo, dw[7:0], 8'h00, 1'b0);
		bus(1'b1, i_hi, dw[15:8], 8'h00, 1'b0);
		ptx <= pw;
		pld <= 1'b1;
		@(posedge clk);
		pld <= 1'b0;
		bus(1'b1, i_stat, 8'h01, 8'h00, 1'b0);
	endtask : xfer
	// low time of the first serial clock pulse
	task automatic half(input int h);
		int n;
		n = 0;
		while (sck_o !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (sck_o === 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk(n == h, "half period");
	endtask : half
	// result monitor: oldest note against each apb answer
	always @(posedge clk) begin
		if (irq === 1'b1) irq_cnt++;
		if (psel && pen && rdy === 1'b1) begin
			e = q.pop_front();
			checks_done++;
			if (serr !== e[8] || (e[9] && rdata !== {24'h00_0000, e[7:0]})) begin
				bad_count++;
				$display("MISMATCH %0t apb answer", $time);
			end
		end
	end
	initial begin
		logic [7:0] b;
		logic [15:0] w;
		int r;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, i_mode, 8'h00, `SSP_MODE_CTRL_RESET, 1'b0);
		bus(1'b0, i_stat, 8'h00, `SSP_CTRL_STAT_RESET, 1'b0);
		bus(1'b0, i_pin + 16'h0001, 8'h00, 8'h00, 1'b1);
		bus(1'b1, i_pin + 16'h0002, 8'hff, 8'h00, 1'b1);
		chk(sck_oe === 1'b1, "clock pin direction");
		for (r = 0; r < 3; r++) begin
			b = $random(seed);
			b[7:6] = r[1:0]; // code 11 never written
			bus(1'b1, i_mode, b, 8'h00, 1'b0);
			bus(1'b0, i_mode, 8'h00, b, 1'b0);
		end
		for (r = 0; r < 8; r++) begin
			b = $random(seed);
			w = $random(seed);
			xfer({5'h00, r[2:0]}, {8'h00, b}, w);
			half(int'(dv[r]) / 2);
			wait_irq;
			chk(prx[15:8] === b, "sent byte");
			bus(1'b0, i_lo, 8'h00, w[7:0], 1'b0);
			// the transmit level keeps the last data bit after the word
			bus(1'b0, i_stat, 8'h00, {1'b1, b[7], 6'h1c}, 1'b0);
		end
		w = $random(seed);
		xfer(8'h45, 16'hc3a5, w);
		wait_irq;
		chk(prx === 16'hc3a5, "word order");
		bus(1'b0, i_lo, 8'h00, w[7:0], 1'b0);
		bus(1'b0, i_hi, 8'h00, w[15:8], 1'b0);
		for (r = 0; r < 2; r++) begin
			b = $random(seed);
			b[7] = ~r[0];
			xfer({3'h1, r[0], 4'h5}, {8'h00, b}, w);
			wait_irq;
			chk(so_o === r[0] && prx[15:7] === {r[0], b}, "tail");
		end
		xfer(8'h00, 16'h00a5, w);
		bus(1'b0, i_stat, 8'h00, 8'h9d, 1'b0);
		r = irq_cnt;
		bus(1'b1, i_mode, 8'h00, 8'h00, 1'b0);
		bus(1'b0, i_stat, 8'h00, 8'h9c, 1'b0);
		repeat (1100) @(posedge clk);
		chk(irq_cnt == r, "irq after abort");
		bus(1'b1, i_mode, 8'h87, 8'h00, 1'b0);
		bus(1'b1, i_stat, 8'h01, 8'h00, 1'b0);
		bus(1'b0, i_stat, 8'h00, 8'h9c, 1'b0);
		r = 0;
		b[0] = sck_o;
		repeat (16) begin
			@(posedge clk);
			r += int'(sck_o !== b[0]);
			b[0] = sck_o;
		end
		chk(r == 16, "clock not continuous");
		chk(so_o === 1'b0, "data pin moved in clock mode");
		bus(1'b1, i_mode, 8'h08, 8'h00, 1'b0);
		chk(sck_oe === 1'b0, "clock pin direction");
		ext_sck <= 1'b0;
		repeat (3) @(posedge clk);
		ext_sck <= 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, i_stat, 8'h00, 8'hbc, 1'b0);
		bus(1'b1, i_stat, 8'h00, 8'h00, 1'b0);
		bus(1'b0, i_stat, 8'h00, 8'h9c, 1'b0);
		bus(1'b1, i_pin, 8'h01, 8'h00, 1'b0);
		bus(1'b1, i_stat, 8'h40, 8'h00, 1'b0);
		chk(so_oe === 1'b0, "open drain high");
		bus(1'b1, i_stat, 8'h00, 8'h00, 1'b0);
		chk(so_oe === 1'b1 && so_o === 1'b0, "open drain low");
		give_verdict;
	end
endmodule : test_sync_serial_tail_mark_port
`default_nettype wire
